// File: logic/isfp_ctrl.sv
// In-system flash programming controller: key-protected chip control, flash
// address/data/control registers, bank switching on wake-up and software reset.
// Assumes the CPU core reports idle and wake-up on this clock and obeys the
// program-counter clear and reset outputs.
//
// Functional notes
// - Two banks, 64K application and 4K loader
// - Chip control writable only after 87H, 59H
// - Any other key value closes write access
// - Flash operations only run while CPU idle
// - Progen bit enters programming at next wake
// - Wake into loader clears PC, RETI to 00H
// - Bits 0, 1, 7 set reset the CPU
// - High and low address bytes form address
// - Data register: write byte, read result
// - Control bit 6 selects target bank
// - Bits 5,4,3..0: output, chip enable, code
// - Erase: code 0010, OE 1, CE 0
// - Program: code 0001, OE 1, CE 0
// - Read: code 0000, OE 0, CE 0
// - Status bit shows loader bank execution
// - Armed software reset returns to application bank
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
module isfp_ctrl
  import isfp_pkg::*;
#(
  parameter int APP_SIZE = APP_BYTES,
  parameter int LDR_SIZE = LDR_BYTES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // CPU core
  input wire logic CPU_IDLE,
  input wire logic CPU_WAKE,
  output logic EXEC_LOADER,
  output logic PC_CLEAR,
  output logic CPU_RESET,
  output logic AUX_RAM_EN,
  output logic WAKE_HOLD,
  // Flash arrays
  output logic FL_REQ,
  output logic [3:0] FL_CTRL,
  output logic FL_OE,
  output logic FL_CE,
  output logic FL_BANK,
  output logic [15:0] FL_ADDR,
  output logic [7:0] FL_WDATA,
  input wire logic FL_ACK,
  input wire logic [7:0] FL_RDATA
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    isfp_key_e key;
    logic [7:0] chip;
    logic exec_ldr;
    logic pend;
    logic [7:0] opc;
    logic [7:0] ah;
    logic [7:0] al;
    logic [7:0] fd;
    logic [7:0] rdata;
    logic pc_clr;
    logic cpu_rst;
  } isfp_ctrl_s;

  isfp_ctrl_s s_q, s_d;
  isfp_op_if op_bus ();

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic op_legal(input logic [7:0] v);
    logic oe;
    logic ce;
    logic [3:0] c;
    oe = v[OPC_OE];
    ce = v[OPC_CE];
    c = v[3:0];
    op_legal = (c == CTRL_ERASE && oe && !ce)
      || (c == CTRL_PROG && oe && !ce)
      || (c == CTRL_READ && !oe && !ce);
  endfunction

  // Loader bank is smaller, so upper address bits are dropped for it
  function automatic logic [15:0] bank_addr(input logic bank, input logic [7:0] hi, input logic [7:0] lo);
    logic [15:0] a;
    a = {hi, lo};
    if (bank) begin
      bank_addr = a & 16'(LDR_SIZE - 1);
    end else begin
      bank_addr = a & 16'(APP_SIZE - 1);
    end
  endfunction

  function automatic logic [7:0] chip_view(input logic [7:0] c, input logic ldr);
    logic [7:0] v;
    v = c & CHIP_WMASK;
    v[CHIP_ONE] = 1'b1;
    v[CHIP_STAT] = ldr;
    chip_view = v;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic sw_armed;
  logic wr_chip;

  always_comb begin
    s_d = s_q;
    s_d.pc_clr = 1'b0;
    s_d.cpu_rst = 1'b0;
    sw_armed = ((s_q.chip & CHIP_SWRST_MASK) == CHIP_SWRST_MASK);
    wr_chip = REG_WR && REG_ADDR == ADR_CHIP && s_q.key == KEY_OPEN;

    // Register writes
    if (REG_WR) begin
      case (REG_ADDR)
        ADR_KEY: begin
          if (REG_WDATA == KEY_FIRST) begin
            s_d.key = KEY_HALF;
          end else if (REG_WDATA == KEY_SECOND && s_q.key == KEY_HALF) begin
            s_d.key = KEY_OPEN;
          end else begin
            s_d.key = KEY_LOCKED;
          end
        end
        ADR_CHIP: begin
          if (wr_chip) begin
            s_d.chip = REG_WDATA & CHIP_WMASK;
          end
        end
        ADR_AH: begin
          s_d.ah = REG_WDATA;
        end
        ADR_AL: begin
          s_d.al = REG_WDATA;
        end
        ADR_FD: begin
          s_d.fd = REG_WDATA;
        end
        ADR_OPC: begin
          s_d.opc = REG_WDATA & OPC_WMASK;
          // Only documented combinations become a flash request
          s_d.pend = op_legal(REG_WDATA);
        end
        default: begin
        end
      endcase
    end

    // Pending request starts once the CPU sits in idle
    if (s_q.pend && CPU_IDLE && !op_bus.busy) begin
      s_d.pend = 1'b0;
    end

    // Read result wins over a software write in the same cycle
    if (op_bus.done && s_q.opc[3:0] == CTRL_READ) begin
      s_d.fd = op_bus.rdata;
    end

    // Read data valid in the cycle after the strobe only
    s_d.rdata = 8'h00;
    if (REG_RD) begin
      case (REG_ADDR)
        ADR_CHIP: begin
          s_d.rdata = chip_view(s_q.chip, s_q.exec_ldr);
        end
        ADR_AH: begin
          s_d.rdata = s_q.ah;
        end
        ADR_AL: begin
          s_d.rdata = s_q.al;
        end
        ADR_FD: begin
          s_d.rdata = s_q.fd;
        end
        ADR_OPC: begin
          s_d.rdata = s_q.opc;
        end
        default: begin
          s_d.rdata = 8'h00;
        end
      endcase
    end

    // Bank switching and software reset
    if (sw_armed && (!CPU_IDLE || CPU_WAKE)) begin
      // Armed outside idle acts at once; armed in idle waits for the timed wake
      s_d = '0;
      s_d.key = KEY_LOCKED;
      s_d.exec_ldr = 1'b0;
      s_d.cpu_rst = 1'b1;
    end else if (CPU_WAKE && s_q.chip[CHIP_PROGEN] && !s_q.exec_ldr) begin
      s_d.exec_ldr = 1'b1;
      s_d.pc_clr = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Operation engine
  // ----------------------------------------
  assign op_bus.start = s_q.pend && CPU_IDLE && !op_bus.busy;
  assign op_bus.ctrl = s_q.opc[3:0];
  assign op_bus.oe = s_q.opc[OPC_OE];
  assign op_bus.ce = s_q.opc[OPC_CE];
  assign op_bus.bank = s_q.opc[OPC_BANK];
  assign op_bus.addr = bank_addr(s_q.opc[OPC_BANK], s_q.ah, s_q.al);
  assign op_bus.wdata = s_q.fd;

  isfp_op_engine u_engine (
    .clk(CLK),
    .sys_rst(SYS_RST),
    .op(op_bus.eng),
    .fl_req(FL_REQ),
    .fl_ctrl(FL_CTRL),
    .fl_oe(FL_OE),
    .fl_ce(FL_CE),
    .fl_bank(FL_BANK),
    .fl_addr(FL_ADDR),
    .fl_wdata(FL_WDATA),
    .fl_ack(FL_ACK),
    .fl_rdata(FL_RDATA)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Holding wake keeps the CPU asleep until the result is in the data register
  assign WAKE_HOLD = s_q.pend || op_bus.busy || op_bus.done;
  assign REG_RDATA = s_q.rdata;
  assign EXEC_LOADER = s_q.exec_ldr;
  assign PC_CLEAR = s_q.pc_clr;
  assign CPU_RESET = s_q.cpu_rst;
  assign AUX_RAM_EN = s_q.chip[CHIP_AUX];

endmodule

// File: logic/isfp_pkg.sv
// Constants shared by the flash programming controller and its operation engine.
// Assumes an 8-bit special-register space with byte addresses.
package isfp_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] ADR_CHIP = 8'hbf;
  localparam logic [7:0] ADR_KEY = 8'hf6;
  localparam logic [7:0] ADR_AL = 8'hc4;
  localparam logic [7:0] ADR_AH = 8'hc5;
  localparam logic [7:0] ADR_FD = 8'hc6;
  localparam logic [7:0] ADR_OPC = 8'hc7;

  // ----------------------------------------
  // Protection key values
  // ----------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'h87;
  localparam logic [7:0] KEY_SECOND = 8'h59;

  // ----------------------------------------
  // Chip control fields
  // ----------------------------------------
  localparam int CHIP_PROGEN = 0;
  localparam int CHIP_BOOTSEL = 1;
  localparam int CHIP_ONE = 3;
  localparam int CHIP_AUX = 4;
  localparam int CHIP_STAT = 5;
  localparam int CHIP_SWRST = 7;
  localparam logic [7:0] CHIP_WMASK = 8'h93;
  localparam logic [7:0] CHIP_SWRST_MASK = 8'h83;

  // ----------------------------------------
  // Operation control fields and codes
  // ----------------------------------------
  localparam int OPC_BANK = 6;
  localparam int OPC_OE = 5;
  localparam int OPC_CE = 4;
  localparam logic [7:0] OPC_WMASK = 8'h7f;
  localparam logic [3:0] CTRL_READ = 4'h0;
  localparam logic [3:0] CTRL_PROG = 4'h1;
  localparam logic [3:0] CTRL_ERASE = 4'h2;

  // ----------------------------------------
  // Reset values and bank sizes
  // ----------------------------------------
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int APP_BYTES = 65536;
  localparam int LDR_BYTES = 4096;

  typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN} isfp_key_e;

endpackage

// File: logic/isfp_op_if.sv
// Carrier between the register side and the flash operation engine.
// Assumes both ends share one clock.
`timescale 1ns/100ps
interface isfp_op_if;
  logic start;
  logic [3:0] ctrl;
  logic oe;
  logic ce;
  logic bank;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  logic busy;
  modport ctl (output start, ctrl, oe, ce, bank, addr, wdata, input done, rdata, busy);
  modport eng (input start, ctrl, oe, ce, bank, addr, wdata, output done, rdata, busy);
endinterface

// File: logic/isfp_op_engine.sv
// Flash operation engine: holds one request to the flash arrays until acknowledged.
// Assumes the arrays run on the same clock and pulse their acknowledge once.
`timescale 1ns/100ps
module isfp_op_engine
  import isfp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Request side
  isfp_op_if.eng op,
  // Flash array side
  output logic fl_req,
  output logic [3:0] fl_ctrl,
  output logic fl_oe,
  output logic fl_ce,
  output logic fl_bank,
  output logic [15:0] fl_addr,
  output logic [7:0] fl_wdata,
  input wire logic fl_ack,
  input wire logic [7:0] fl_rdata
);

  typedef enum logic {ENG_IDLE, ENG_REQ} isfp_eng_e;
  typedef struct packed {
    isfp_eng_e st;
    logic [3:0] ctrl;
    logic oe;
    logic ce;
    logic bank;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic done;
  } isfp_eng_s;

  isfp_eng_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      ENG_IDLE: begin
        if (op.start) begin
          s_d.st = ENG_REQ;
          s_d.ctrl = op.ctrl;
          s_d.oe = op.oe;
          s_d.ce = op.ce;
          s_d.bank = op.bank;
          // Erase uses neither address nor data; keep them quiet on the pins
          s_d.addr = (op.ctrl == CTRL_ERASE) ? 16'h0000 : op.addr;
          s_d.wdata = (op.ctrl == CTRL_PROG) ? op.wdata : 8'h00;
        end
      end
      ENG_REQ: begin
        if (fl_ack) begin
          s_d.st = ENG_IDLE;
          s_d.done = 1'b1;
          if (s_q.ctrl == CTRL_READ) begin
            s_d.rdata = fl_rdata;
          end
        end
      end
      default: begin
        s_d.st = ENG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign fl_req = (s_q.st == ENG_REQ);
  assign fl_ctrl = s_q.ctrl;
  assign fl_oe = s_q.oe;
  assign fl_ce = s_q.ce;
  assign fl_bank = s_q.bank;
  assign fl_addr = s_q.addr;
  assign fl_wdata = s_q.wdata;
  assign op.done = s_q.done;
  assign op.rdata = s_q.rdata;
  assign op.busy = (s_q.st != ENG_IDLE);

endmodule

// File: dv/isfp_flash_model.sv
// Behavioural model of the application and loader flash arrays.
// Assumes the controller's clock; each request is acknowledged after a short random delay.
`timescale 1ns/100ps
module isfp_flash_model (
  // Clock
  input wire logic clk,
  // Request from the controller
  input wire logic req,
  input wire logic [3:0] ctrl,
  input wire logic bank,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  // Answer
  output logic ack,
  output logic [7:0] rdata
);
  logic [7:0] app_mem [65536];
  logic [7:0] ldr_mem [4096];
  initial begin
    ack = 1'b0;
    rdata = 8'h00;
    forever begin
      @(posedge clk);
      if (req) begin
        repeat ($urandom % 4) @(posedge clk);
        case (ctrl)
          4'h2: if (bank) foreach (ldr_mem[n]) ldr_mem[n] = 8'hff; else foreach (app_mem[n]) app_mem[n] = 8'hff;
          4'h1: if (bank) ldr_mem[addr[11:0]] = wdata; else app_mem[addr] = wdata;
          default: rdata <= bank ? ldr_mem[addr[11:0]] : app_mem[addr];
        endcase
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        // Released data line must not keep the old value
        rdata <= ~rdata;
      end
    end
  end
endmodule

// File: dv/isfp_ctrl_chk.sv
// Port-level assertions for the flash programming controller.
// Assumes one clock with synchronous active-high reset.
`timescale 1ns/100ps
module isfp_ctrl_chk
  import isfp_pkg::*;
#(
  parameter int APP_SIZE = APP_BYTES,
  parameter int LDR_SIZE = LDR_BYTES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  // CPU core
  input wire logic CPU_IDLE,
  input wire logic EXEC_LOADER,
  input wire logic PC_CLEAR,
  input wire logic CPU_RESET,
  // Flash arrays
  input wire logic FL_REQ,
  input wire logic [3:0] FL_CTRL,
  input wire logic FL_OE,
  input wire logic FL_CE,
  input wire logic FL_BANK,
  input wire logic [15:0] FL_ADDR,
  input wire logic FL_ACK
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_chip_view: assert property ($past(REG_RD) && $past(REG_ADDR) == ADR_CHIP |->
    REG_RDATA[5] == $past(EXEC_LOADER) && REG_RDATA[3]) else $error("chip status view wrong");
  a_req_idle: assert property ($rose(FL_REQ) |-> $past(CPU_IDLE)) else $error("flash request outside idle");
  a_req_hold: assert property (FL_REQ && !FL_ACK |=> FL_REQ && $stable(FL_ADDR) && $stable(FL_CTRL))
    else $error("flash request not held");
  a_req_end: assert property (FL_REQ && FL_ACK |=> !FL_REQ) else $error("flash request kept after ack");
  a_op_form: assert property (FL_REQ |-> !FL_CE && FL_CTRL <= 4'h2 && FL_OE == (FL_CTRL != 4'h0))
    else $error("illegal flash request form");
  a_erase_addr: assert property (FL_REQ && FL_CTRL == 4'h2 |-> FL_ADDR == 16'h0000) else $error("erase address");
  a_ldr_range: assert property (FL_REQ && FL_BANK |-> FL_ADDR < LDR_SIZE) else $error("loader address range");
  a_pc_clear: assert property (PC_CLEAR |-> EXEC_LOADER && !$past(EXEC_LOADER)) else $error("stray pc clear");
  a_enter_ldr: assert property ($rose(EXEC_LOADER) |-> PC_CLEAR) else $error("loader entry without pc clear");
  a_sw_reset: assert property (CPU_RESET |-> !EXEC_LOADER ##1 !CPU_RESET) else $error("software reset pulse");
endmodule

bind isfp_ctrl isfp_ctrl_chk #(.APP_SIZE(APP_SIZE), .LDR_SIZE(LDR_SIZE)) u_isfp_ctrl_chk (
  .CLK(CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .CPU_IDLE(CPU_IDLE), .EXEC_LOADER(EXEC_LOADER), .PC_CLEAR(PC_CLEAR), .CPU_RESET(CPU_RESET),
  .FL_REQ(FL_REQ), .FL_CTRL(FL_CTRL), .FL_OE(FL_OE), .FL_CE(FL_CE), .FL_BANK(FL_BANK),
  .FL_ADDR(FL_ADDR), .FL_ACK(FL_ACK));

// File: dv/isfp_ctrl_tb.sv
// Self-checking bench for the flash programming controller.
// Assumes the flash model answers every request within a few cycles.
`timescale 1ns/100ps
module isfp_ctrl_tb;
  import isfp_pkg::*;
  logic clk = 1'b0;
  logic sys_rst, reg_wr, reg_rd, cpu_idle, cpu_wake, exec_loader, pc_clear, cpu_reset, aux_ram_en;
  logic wake_hold, fl_req, fl_oe, fl_ce, fl_bank, fl_ack, b;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, fl_wdata, fl_rdata, d;
  logic [3:0] fl_ctrl;
  logic [15:0] fl_addr, a;
  int errors = 0;
  int compares = 0;
  always #5 clk = ~clk;
  isfp_ctrl u_isfp_ctrl (.CLK(clk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CPU_IDLE(cpu_idle), .CPU_WAKE(cpu_wake),
    .EXEC_LOADER(exec_loader), .PC_CLEAR(pc_clear), .CPU_RESET(cpu_reset), .AUX_RAM_EN(aux_ram_en),
    .WAKE_HOLD(wake_hold), .FL_REQ(fl_req), .FL_CTRL(fl_ctrl), .FL_OE(fl_oe), .FL_CE(fl_ce),
    .FL_BANK(fl_bank), .FL_ADDR(fl_addr), .FL_WDATA(fl_wdata), .FL_ACK(fl_ack), .FL_RDATA(fl_rdata));
  isfp_flash_model u_isfp_flash_model (.clk(clk), .req(fl_req), .ctrl(fl_ctrl), .bank(fl_bank),
    .addr(fl_addr), .wdata(fl_wdata), .ack(fl_ack), .rdata(fl_rdata));
  // ------
  // Tasks
  // ------
  task automatic print_verdict();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  // Waits until the pending or running operation has fully landed
  task automatic op(input logic [7:0] code);
    wr(ADR_OPC, code);
    #1;
    repeat (40) begin
      if (wake_hold === 1'b0) return;
      @(posedge clk);
      #1;
    end
    errors++;
    $display("MISMATCH t=%0t operation never finished", $time);
    print_verdict();
  endtask
  task automatic access(input logic bk, input logic [15:0] ad, input logic [7:0] dt);
    wr(ADR_AH, ad[15:8]);
    wr(ADR_AL, ad[7:0]);
    wr(ADR_FD, dt);
    op({1'b0, bk, 6'h21});
    wr(ADR_FD, ~dt);
    op({1'b0, bk, 6'h00});
    rd(ADR_FD, dt);
  endtask
  task automatic wake();
    @(posedge clk);
    cpu_wake <= 1'b1;
    cpu_idle <= 1'b0;
    @(posedge clk);
    cpu_wake <= 1'b0;
    #1;
  endtask
  // ------
  // Main sequence
  // ------
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, cpu_wake, cpu_idle} = '0;
    sys_rst = 1'b1;
    void'($urandom(32'hc4fb0936));
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ADR_CHIP, 8'h08);
    wr(ADR_CHIP, 8'h11);
    rd(ADR_CHIP, 8'h08);
    wr(ADR_KEY, KEY_FIRST);
    wr(ADR_KEY, KEY_SECOND);
    wr(ADR_CHIP, 8'h11);
    rd(ADR_CHIP, 8'h19);
    check({7'h00, aux_ram_en}, 8'h01);
    wr(ADR_KEY, 8'h3c);
    wr(ADR_CHIP, 8'h00);
    rd(ADR_CHIP, 8'h19);
    rd(8'h00, 8'h00);
    wr(ADR_OPC, 8'h00);
    repeat (10) @(posedge clk);
    check({7'h00, fl_req}, 8'h00);
    cpu_idle <= 1'b1;
    op(8'h00);
    for (int k = 0; k < 8; k++) begin
      a = 16'($urandom);
      d = 8'($urandom);
      b = k[0];
      if (b) a[15:12] = 4'h0;
      access(b, a, d);
    end
    access(1'b0, 16'h0fff, 8'h5a);
    access(1'b1, 16'h0fff, 8'ha5);
    op(8'h00);
    rd(ADR_FD, 8'h5a);
    op(8'h62);
    op(8'h40);
    rd(ADR_FD, 8'hff);
    op(8'h00);
    rd(ADR_FD, 8'h5a);
    wr(ADR_KEY, KEY_FIRST);
    wr(ADR_KEY, KEY_SECOND);
    wr(ADR_CHIP, 8'h01);
    wake();
    check({7'h00, exec_loader}, 8'h01);
    rd(ADR_CHIP, 8'h29);
    cpu_idle <= 1'b1;
    wr(ADR_CHIP, 8'h83);
    repeat (3) @(posedge clk);
    #1 check({6'h00, cpu_reset, exec_loader}, 8'h01);
    wake();
    check({6'h00, cpu_reset, exec_loader}, 8'h02);
    rd(ADR_CHIP, 8'h08);
    print_verdict();
  end
endmodule
